// ===== rtl/cstc_pkg.sv
package cstc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_APPLY  = 12'h232;
  localparam logic [11:0] ADDR_TABLE  = 12'ha00;
  localparam logic [11:0] ADDR_BUSY   = 12'hb00;
  localparam logic [11:0] ADDR_ERROR  = 12'hb01;
  localparam logic [11:0] ADDR_CTRL   = 12'hb02;
  localparam logic [11:0] ADDR_SAVE   = 12'hb03;
  localparam int          BIT_APPLY   = 0;
  localparam int          BIT_WREN    = 0;
  localparam int          BIT_SOFT    = 1;
  localparam int          BIT_SAVE    = 0;
  localparam logic        WREN_RESET  = 1'b0;

  // ----------------------------------------------------------------
  // Segment table layout
  // ----------------------------------------------------------------
  // A record is three bytes: count minus one (bit 7 clear), address high, address low.
  localparam int          TABLE_DEPTH = 23;
  localparam int          STORE_AW    = 11;
  localparam logic [7:0]  OP_APPLY    = 8'ha0;
  localparam logic [7:0]  OP_END      = 8'hff;
  localparam int          OP_FLAG_BIT = 7;
  localparam logic [7:0]  TABLE_RESET [TABLE_DEPTH] = '{
    8'h7f, 8'h00, 8'h00,
    8'h7f, 8'h00, 8'h80,
    8'h7f, 8'h01, 8'h00,
    8'h7f, 8'h01, 8'h80,
    8'h32, 8'h02, 8'h00,
    8'ha0, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff
  };

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_DECODE, S_ADDR_HI, S_ADDR_LO, S_READ_BUF, S_STORE_REQ, S_STORE_WAIT
  } cstc_state_type;

  typedef struct packed {
    logic                req;
    logic                we;
    logic [STORE_AW-1:0] addr;
    logic [7:0]          wdata;
  } cstc_store_req_type;

  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } cstc_buf_wr_type;

endpackage : cstc_pkg

// ===== rtl/cstc_transfer_ctrl.sv
`timescale 1ns/1ps
module cstc_transfer_ctrl
  import cstc_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [11:0]        reg_addr,
  input  wire logic [7:0]         reg_wdata,
  output logic      [7:0]         reg_rdata,
  input  wire logic               sclk,
  input  wire logic               store_pin_n,
  input  wire logic               status_sel,
  output logic                    status_pin,
  output logic                    apply_pulse,
  output logic                    device_reset,
  output cstc_buf_wr_type         buf_port,
  input  wire logic [7:0]         buf_rdata,
  output cstc_store_req_type      store_port,
  input  wire logic [7:0]         store_rdata,
  input  wire logic               store_ack,
  input  wire logic               store_data_ok
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]          seg_table [TABLE_DEPTH];
  cstc_state_type      state;
  logic [4:0]          idx;
  logic [6:0]          count;
  logic [11:0]         cur_addr;
  logic [STORE_AW-1:0] store_ptr;
  logic                dir_save;
  logic                busy;
  logic                error;
  logic                err_run;
  logic                wren;
  logic                soft_bit;
  logic                save_cmd;
  logic                sclk_s1;
  logic                sclk_s2;
  logic                sclk_s3;
  logic                pin_s1;
  logic                pin_s2;
  logic                sclk_rise;
  logic                wr_apply;
  logic                wr_ctrl;
  logic                wr_save;
  logic                start_save;
  logic                start_soft;
  logic                entry_end;
  logic [7:0]          entry;

  // Out-of-range indices read as end of data so a full table still terminates.
  function automatic logic [7:0] table_at(input logic [4:0] i);
    logic [7:0] v;
    v = OP_END;
    if (32'(i) < TABLE_DEPTH) begin
      v = seg_table[i];
    end
    return v;
  endfunction : table_at

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Serial clock and store-select pin come from outside the clock domain.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      pin_s1  <= 1'b1;
      pin_s2  <= 1'b1;
    end else begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      pin_s1  <= store_pin_n;
      pin_s2  <= pin_s1;
    end
  end

  // Write decode and start conditions.
  assign sclk_rise  = sclk_s2 && !sclk_s3;
  assign wr_apply   = reg_wr && reg_addr == ADDR_APPLY && reg_wdata[BIT_APPLY];
  assign wr_ctrl    = reg_wr && reg_addr == ADDR_CTRL;
  assign wr_save    = reg_wr && reg_addr == ADDR_SAVE && reg_wdata[BIT_SAVE];
  // A save without write enable is dropped, protecting the store.
  assign start_save = wr_save && wren && !busy;
  assign start_soft = wr_ctrl && reg_wdata[BIT_SOFT] && !pin_s2 && !busy;
  assign entry      = table_at(idx);
  assign entry_end  = state == S_DECODE && entry == OP_END;

  // ----------------------------------------------------------------
  // Control register bits
  // ----------------------------------------------------------------
  // Write enable; a soft reset returns it to its protected default.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wren <= WREN_RESET;
    end else if (start_soft) begin
      wren <= WREN_RESET;
    end else if (wr_ctrl) begin
      wren <= reg_wdata[BIT_WREN];
    end
  end

  // The soft bit lingers until the serial clock ticks once after the write.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      soft_bit <= 1'b0;
    end else if (wr_ctrl && reg_wdata[BIT_SOFT]) begin
      soft_bit <= 1'b1;
    end else if (sclk_rise) begin
      soft_bit <= 1'b0;
    end
  end

  // Save command stays set for the whole save and clears at its end.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      save_cmd <= 1'b0;
    end else if (start_save) begin
      save_cmd <= 1'b1;
    end else if (entry_end) begin
      save_cmd <= 1'b0;
    end
  end

  // Segment table; soft reset restores the full-copy layout before reloading.
  always_ff @(posedge clock) begin
    if (!rst_n || start_soft) begin
      for (int i = 0; i < TABLE_DEPTH; i++) begin
        seg_table[i] <= TABLE_RESET[i];
      end
    end else if (reg_wr && reg_addr >= ADDR_TABLE
                 && reg_addr < ADDR_TABLE + 12'(TABLE_DEPTH)) begin
      seg_table[5'(reg_addr - ADDR_TABLE)] <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  // Walks the segment table, moving one byte per store handshake.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state      <= S_IDLE;
      idx        <= 5'h00;
      count      <= 7'h00;
      cur_addr   <= 12'h000;
      store_ptr  <= '0;
      dir_save   <= 1'b0;
      busy       <= 1'b0;
      error      <= 1'b0;
      err_run    <= 1'b0;
      store_port <= '0;
      buf_port   <= '0;
    end else begin
      buf_port.we <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (start_save || start_soft) begin
            state     <= S_DECODE;
            dir_save  <= start_save;
            idx       <= 5'h00;
            store_ptr <= '0;
            err_run   <= 1'b0;
            busy      <= 1'b1;
          end
        end
        S_DECODE: begin
          if (entry == OP_END) begin
            state <= S_IDLE;
            busy  <= 1'b0;
            error <= err_run;
          end else if (entry == OP_APPLY) begin
            idx <= idx + 5'h01;
          end else if (entry[OP_FLAG_BIT]) begin
            idx <= idx + 5'h01;
          end else begin
            count <= entry[6:0];
            idx   <= idx + 5'h01;
            state <= S_ADDR_HI;
          end
        end
        S_ADDR_HI: begin
          cur_addr[11:8] <= entry[3:0];
          idx            <= idx + 5'h01;
          state          <= S_ADDR_LO;
        end
        S_ADDR_LO: begin
          cur_addr[7:0] <= entry;
          idx           <= idx + 5'h01;
          state         <= dir_save ? S_READ_BUF : S_STORE_REQ;
        end
        S_READ_BUF: begin
          buf_port.addr <= cur_addr;
          state         <= S_STORE_REQ;
        end
        S_STORE_REQ: begin
          store_port.req   <= 1'b1;
          store_port.we    <= dir_save;
          store_port.addr  <= store_ptr;
          store_port.wdata <= buf_rdata;
          state            <= S_STORE_WAIT;
        end
        S_STORE_WAIT: begin
          if (store_ack) begin
            store_port.req <= 1'b0;
            store_ptr      <= store_ptr + 1'b1;
            if (!store_data_ok) begin
              err_run <= 1'b1;
            end
            if (!dir_save) begin
              buf_port.we    <= 1'b1;
              buf_port.addr  <= cur_addr;
              buf_port.wdata <= store_rdata;
            end
            if (count == 7'h00) begin
              state <= S_DECODE;
            end else begin
              count    <= count - 7'h01;
              cur_addr <= cur_addr + 12'h001;
              state    <= dir_save ? S_READ_BUF : S_STORE_REQ;
            end
          end
        end
        // Code 7 is not a state; fall back to idle rather than lock up.
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pulses, status pin and read data
  // ----------------------------------------------------------------
  // Apply comes from the host bit or from the opcode while restoring; saves skip it.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      apply_pulse  <= 1'b0;
      device_reset <= 1'b0;
      status_pin   <= 1'b0;
    end else begin
      apply_pulse  <= wr_apply
                      || (state == S_DECODE && entry == OP_APPLY && !dir_save);
      device_reset <= start_soft;
      status_pin   <= status_sel && busy;
    end
  end

  // The update register holds nothing, so it always reads back as zero.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr >= ADDR_TABLE && reg_addr < ADDR_TABLE + 12'(TABLE_DEPTH)) begin
        reg_rdata <= seg_table[5'(reg_addr - ADDR_TABLE)];
      end else if (reg_addr == ADDR_BUSY) begin
        reg_rdata <= {7'h00, busy};
      end else if (reg_addr == ADDR_ERROR) begin
        reg_rdata <= {7'h00, error};
      end else if (reg_addr == ADDR_CTRL) begin
        reg_rdata <= {6'h00, soft_bit, wren};
      end else if (reg_addr == ADDR_SAVE) begin
        reg_rdata <= {7'h00, save_cmd};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  apply_write_a: assert property (wr_apply |=> apply_pulse ##1 !apply_pulse || wr_apply)
    else $error("update write did not give a one-cycle apply pulse");
  apply_reads_a: assert property (reg_rd && reg_addr == ADDR_APPLY |=> reg_rdata == 8'h00)
    else $error("update register did not read as zero");
  busy_start_a: assert property (state == S_IDLE && (start_save || start_soft) |=> busy && state == S_DECODE)
    else $error("busy not raised when a transfer started");
  status_pin_a: assert property (busy && status_sel |=> status_pin)
    else $error("status pin does not follow busy");
  end_done_a: assert property (entry_end |=> !busy && state == S_IDLE && error == $past(err_run))
    else $error("end of data did not finish the transfer");
  save_guard_a: assert property ($rose(save_cmd) |-> $past(wren))
    else $error("save started while writes were protected");
  soft_clear_a: assert property (soft_bit && sclk_rise && !wr_ctrl |=> !soft_bit)
    else $error("soft bit did not clear on the serial clock");
  save_clear_a: assert property (entry_end && dir_save |=> !save_cmd && !busy)
    else $error("save bit did not clear at end of save");
  soft_reload_a: assert property (start_soft |=> device_reset && busy && !dir_save)
    else $error("soft reset did not start a reload");
  error_seen_a: assert property (busy && store_ack && !store_data_ok && state == S_STORE_WAIT
                                 |=> err_run)
    else $error("bad store data was not recorded");

endmodule : cstc_transfer_ctrl

// ===== sim/cstc_store_model.sv
`timescale 1ns/1ps
module cstc_store_model
  import cstc_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire cstc_store_req_type store_port,
  input  wire logic               slow,
  input  wire logic               corrupt,
  output logic [7:0]              store_rdata,
  output logic                    store_ack,
  output logic                    store_data_ok
);
  logic [7:0] mem [0:(1<<STORE_AW)-1];
  logic [1:0] wait_cnt;

  // Known pattern so that restored bytes can be predicted by the bench.
  initial begin
    for (int i = 0; i < (1 << STORE_AW); i++) mem[i] = 8'(i * 3);
    store_rdata = 8'h00;
    store_ack = 1'b0;
    store_data_ok = 1'b1;
    wait_cnt = 2'h0;
  end

  // One access per request; read data toggles outside the ack cycle so stale data never looks valid.
  always @(posedge clock) begin
    store_ack <= 1'b0;
    store_data_ok <= 1'b1;
    store_rdata <= ~store_rdata;
    if (!rst_n) begin
      wait_cnt <= 2'h0;
    end else if (store_port.req && !store_ack) begin
      if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
        store_ack <= 1'b1;
        wait_cnt <= 2'h0;
        store_data_ok <= !(corrupt && store_port.addr == 11'h005);
        if (store_port.we) mem[store_port.addr] <= store_port.wdata;
        else store_rdata <= mem[store_port.addr];
      end else begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule : cstc_store_model

// ===== sim/test_cstc_transfer_ctrl.sv
`timescale 1ns/1ps
module test_cstc_transfer_ctrl;
  import cstc_pkg::*;
  logic               clock, rst_n, reg_wr, reg_rd, sclk, store_pin_n, status_sel;
  logic [11:0]        reg_addr;
  logic [7:0]         reg_wdata, reg_rdata, buf_rdata, store_rdata, rv;
  logic               status_pin, apply_pulse, device_reset, store_ack, store_data_ok;
  logic               slow, corrupt;
  cstc_buf_wr_type    buf_port;
  cstc_store_req_type store_port;
  logic [7:0]         bank [0:4095];
  int                 n_mismatch, samples_checked, n_apply;

  cstc_transfer_ctrl cstc_transfer_ctrl_inst (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sclk(sclk), .store_pin_n(store_pin_n), .status_sel(status_sel),
    .status_pin(status_pin), .apply_pulse(apply_pulse), .device_reset(device_reset),
    .buf_port(buf_port), .buf_rdata(buf_rdata), .store_port(store_port),
    .store_rdata(store_rdata), .store_ack(store_ack), .store_data_ok(store_data_ok));
  cstc_store_model cstc_store_model_inst (.clock(clock), .rst_n(rst_n),
    .store_port(store_port), .slow(slow), .corrupt(corrupt), .store_rdata(store_rdata),
    .store_ack(store_ack), .store_data_ok(store_data_ok));

  // ----------------------------------------------------------------
  // Buffer bank and clock
  // ----------------------------------------------------------------
  // The bank reads combinationally, as the design expects during a save.
  assign buf_rdata = bank[buf_port.addr];
  always @(posedge clock) begin
    if (buf_port.we) bank[buf_port.addr] <= buf_port.wdata;
    if (apply_pulse === 1'b1) n_apply <= n_apply + 1;
  end
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  // Polls the busy register under a bound so a stuck transfer cannot hang the run.
  task automatic wait_idle();
    for (int i = 0; i < 4000; i++) begin
      rd(ADDR_BUSY);
      if (rv === 8'h00) return;
    end
    check("busy timeout", rv, 8'h00);
  endtask : wait_idle
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // Whole sequence needs about two thousand cycles; twenty-five times that means a hang.
  initial begin
    repeat (50000) @(posedge clock);
    n_mismatch++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {reg_wr, reg_rd, sclk, rst_n, slow, corrupt} = '0;
    {store_pin_n, status_sel} = 2'b11;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    {n_mismatch, samples_checked, n_apply} = '0;
    for (int i = 0; i < 4096; i++) bank[i] = 8'(i) ^ 8'h5a;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd(ADDR_CTRL);   check("ctrl reset", rv, 8'h00);
    rd(ADDR_TABLE);  check("table first", rv, 8'h7f);
    rd(12'ha0f);     check("table opcode", rv, 8'ha0);
    rd(12'ha10);     check("table end", rv, 8'hff);
    rd(12'hb07);     check("unmapped", rv, 8'h00);
    $display("test reset values done");
    wr(ADDR_APPLY, 8'h01);
    #1 check("apply pulse", {7'h0, apply_pulse}, 8'h01);
    @(posedge clock);
    #1 check("apply drop", {7'h0, apply_pulse}, 8'h00);
    wr(ADDR_APPLY, 8'h01);
    #1 check("apply again", {7'h0, apply_pulse}, 8'h01);
    rd(ADDR_APPLY);  check("apply reads", rv, 8'h00);
    $display("test apply done");
    wr(ADDR_SAVE, 8'h01);
    rd(ADDR_BUSY);   check("save blocked", rv, 8'h00);
    $display("test write protect done");
    // Short table: three bytes from 0x010, then apply and end, to keep the save brief.
    wr(ADDR_TABLE, 8'h02);
    wr(12'ha01, 8'h00);
    wr(12'ha02, 8'h10);
    wr(12'ha03, OP_APPLY);
    wr(12'ha04, OP_END);
    rd(12'ha02);     check("table rw", rv, 8'h10);
    slow <= 1'b1;
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_SAVE, 8'h01);
    rd(ADDR_SAVE);   check("save bit", rv, 8'h01);
    rd(ADDR_BUSY);   check("busy", rv, 8'h01);
    check("status pin", {7'h0, status_pin}, 8'h01);
    wait_idle();
    rd(ADDR_SAVE);   check("save clear", rv, 8'h00);
    rd(ADDR_ERROR);  check("save error", rv, 8'h00);
    check("status idle", {7'h0, status_pin}, 8'h00);
    for (int i = 0; i < 3; i++)
      check("stored byte", cstc_store_model_inst.mem[i], 8'(8'h10 + i) ^ 8'h5a);
    $display("test save done");
    // Restore with default table and one corrupted byte.
    slow <= 1'b0;
    corrupt <= 1'b1;
    store_pin_n <= 1'b0;
    n_apply = 0;
    repeat (4) @(posedge clock);
    wr(ADDR_CTRL, 8'h02);
    rv = 8'h00;
    // The pulse is launched at the write's last edge, so look before waiting.
    for (int i = 0; i < 20; i++) begin
      #1 if (device_reset === 1'b1) rv = 8'h01;
      @(posedge clock);
    end
    check("soft reset", rv, 8'h01);
    repeat (2) begin
      repeat (3) @(posedge clock);
      sclk <= 1'b1;
      repeat (3) @(posedge clock);
      sclk <= 1'b0;
    end
    repeat (6) @(posedge clock);
    rd(ADDR_CTRL);   check("soft clear", rv, 8'h00);
    status_sel <= 1'b0;
    repeat (2) @(posedge clock);
    #1 check("status masked", {7'h0, status_pin}, 8'h00);
    status_sel <= 1'b1;
    wait_idle();
    rd(ADDR_ERROR);  check("restore error", rv, 8'h01);
    check("apply count", 8'(n_apply), 8'h01);
    check("restored lo", bank[12'h010], 8'h30);
    check("restored hi", bank[12'h201], 8'h03);
    $display("test restore done");
    final_report();
  end
endmodule : test_cstc_transfer_ctrl
